// ### rtl/vafc_pkg.sv
/*
 Constants shared by the oscillator band calibration block.
 Assumes a word-per-register map behind an Avalon-MM slave.
*/
package vafc_pkg;
	// Register indices; the byte address is four times the index
	localparam logic [4:0] IDX_INT = 5'h03;
	localparam logic [4:0] IDX_FRAC = 5'h04;
	localparam logic [4:0] IDX_MODE = 5'h06;
	localparam logic [4:0] IDX_CAL = 5'h0a;
	localparam logic [4:0] IDX_BAND = 5'h15;
	localparam logic [4:0] IDX_OUT = 5'h16;
	localparam logic [4:0] IDX_MUTE = 5'h17;
	localparam logic [4:0] IDX_STAT = 5'h1f;
	// Field positions
	localparam int MODE_FRAC_BIT = 11;
	localparam int CAL_N_LSB = 0;
	localparam int CAL_OFF_BIT = 11;
	localparam int CAL_M_LSB = 13;
	localparam int BAND_LSB = 1;
	localparam int OUT_DIV_LSB = 0;
	localparam int OUT_GAIN_LSB = 6;
	localparam int MUTE_CAL_BIT = 7;
	localparam int BUSY_BIT = 0;
	// Reset values, and the first band of each search
	localparam logic [18:0] RST_INT = 19'h00010;
	localparam logic [5:0] RST_DIV = 6'h01;
	localparam logic [4:0] RST_GAIN = 5'h00;
	localparam logic [7:0] FIRST_BAND = 8'h80;
	// Calibration timing in state-machine ticks; MEAS_COUNT is a count of measurements
	localparam logic [8:0] WAIT_TICKS = 9'h180;
	localparam logic [4:0] XFER_TICKS = 5'h14;
	localparam logic [4:0] SER_BITS = 5'h10;
	localparam logic [2:0] MEAS_COUNT = 3'h6;
	typedef enum logic [2:0] {
		CAL_IDLE = 3'h0,
		CAL_WAITK = 3'h1,
		CAL_XFER = 3'h2,
		CAL_MEAS = 3'h3,
		CAL_LOAD = 3'h4
	} vafc_state_type;
endpackage

// ### rtl/vafc_vco_auto_band_calibration.sv
/*
 Band calibration and frequency-change control of a step-tuned
 oscillator, with its register file on an Avalon-MM slave.
 Assumes clock is the reference, vcoPulses gives the oscillator
 cycles seen in each reference cycle, and refDivider is R.
*/
// Summary of operation
// - Divided state-machine clock also paces the 16-bit band serial port.
// - Tick rate changes calibration time only, never measurement result.
// - Length code 0..7 maps to exponent 0,1,2,3,5,6,7,8.
// - Exponents m=0, n=5 at 50 MHz resolve about 1.56 MHz.
// - After final band load the pending fraction goes to the modulator.
// - Chosen band reads back in band register bits 8:1.
// - With calibration off, band writes reach the oscillator at once.
// - Mode bit 11 set selects fraction; integer rewritten only on change.
// - Fractional write with calibration on starts it, loads afterwards.
// - Fractional write with calibration off loads modulator at once.
// - Mode bit 11 clear selects integer; change needs integer write.
// - Integer-mode integer write, calibration on, starts it; loads after.
// - Integer write with calibration off loads prescaler at once.
// - Output gain bits 10:6 change apart from divider bits 5:0.
// - Divider zero keeps outputs muted.
// - Mute-on-calibration bit mutes outputs while calibrating.
// - Muting gates the output only; loop and oscillator keep running.
// - Frequency write of the selected mode, calibration on, same value too, restarts calibration.
// - Each measurement spans R times 2^n reference cycles.
// - Tick exponent m is 0, 2, 4 or 5 from bits 14:13.
`timescale 1ns/100ps
module vafc_vco_auto_band_calibration (
	input wire logic clock,
	input wire logic srst,
	input wire logic [6:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic [13:0] refDivider,
	input wire logic [7:0] vcoPulses,
	output logic [7:0] bandSwitch,
	output logic [18:0] prescalerInt,
	output logic [23:0] modulatorFrac,
	output logic [4:0] outputGain,
	output logic [5:0] outputDivider,
	output logic outputMute,
	output logic calBusy,
	output logic oscSerialData,
	output logic oscSerialStrobe,
	output logic oscSerialEnable
);
	typedef struct packed {
		logic waitReq;
		logic [31:0] rdData;
		logic [18:0] intReg;
		logic [23:0] fracReg;
		logic fracMode;
		logic [2:0] nCode;
		logic calOff;
		logic [1:0] mCode;
		logic [7:0] bandReg;
		logic [7:0] bandOut;
		logic [4:0] gain;
		logic [5:0] divider;
		logic muteCal;
		logic [18:0] prescInt;
		logic [23:0] sdFrac;
		logic mute;
		logic busy;
		vafc_pkg::vafc_state_type fsm;
		logic [4:0] preCnt;
		logic [8:0] tickCnt;
		logic [21:0] winCnt;
		logic [31:0] vcoCnt;
		logic [7:0] trial;
		logic [7:0] best;
		logic [31:0] bestErr;
		logic [2:0] bitIdx;
		logic [2:0] measLeft;
		logic [15:0] shift;
		logic serData;
		logic serStrobe;
		logic serEn;
	} vafc_regs_type;

	vafc_regs_type st_reg;
	vafc_regs_type st_next;
	logic [4:0] idx;
	logic [3:0] nExp;
	logic [2:0] mExp;
	logic [4:0] preLimit;
	logic tick;
	logic [21:0] winLast;
	logic [50:0] scaled;
	logic [31:0] expCount;
	logic [31:0] total;
	logic [31:0] err;
	logic [7:0] newBest;
	logic [7:0] decided;
	logic [31:0] rdMux;
	logic req;
	logic wrAck;
	logic startCal;

	// Exponent decode; code 4 skips n=4
	always_comb begin
		nExp = (st_reg.nCode < 3'h4) ? {1'b0, st_reg.nCode} :
			{1'b0, st_reg.nCode} + 4'h1;
		unique case (st_reg.mCode)
			2'h0: mExp = 3'h0;
			2'h1: mExp = 3'h2;
			2'h2: mExp = 3'h4;
			2'h3: mExp = 3'h5;
		endcase
	end

	// Tick divider, window length and expected count
	always_comb begin
		preLimit = 5'((6'h01 << mExp) - 6'h01);
		tick = (st_reg.preCnt == preLimit);
		// Window counts reference cycles, so tick rate cannot skew it
		winLast = 22'((22'(refDivider) << nExp) - 22'h1);
		scaled = {8'h00, st_reg.intReg, st_reg.fracReg} << nExp;
		expCount = {5'h00, scaled[50:24]};
		total = st_reg.vcoCnt + {24'h000000, vcoPulses};
		err = (total >= expCount) ? total - expCount : expCount - total;
	end

	// Read data; unmapped indices read zero
	always_comb begin
		idx = address[6:2];
		unique case (idx)
			vafc_pkg::IDX_INT: rdMux = {13'h0000, st_reg.intReg};
			vafc_pkg::IDX_FRAC: rdMux = {8'h00, st_reg.fracReg};
			vafc_pkg::IDX_MODE:
				rdMux = 32'(st_reg.fracMode) << vafc_pkg::MODE_FRAC_BIT;
			vafc_pkg::IDX_CAL:
				rdMux = (32'(st_reg.nCode) << vafc_pkg::CAL_N_LSB) |
					(32'(st_reg.calOff) << vafc_pkg::CAL_OFF_BIT) |
					(32'(st_reg.mCode) << vafc_pkg::CAL_M_LSB);
			vafc_pkg::IDX_BAND:
				rdMux = 32'(st_reg.bandReg) << vafc_pkg::BAND_LSB;
			vafc_pkg::IDX_OUT:
				rdMux = (32'(st_reg.divider) << vafc_pkg::OUT_DIV_LSB) |
					(32'(st_reg.gain) << vafc_pkg::OUT_GAIN_LSB);
			vafc_pkg::IDX_MUTE:
				rdMux = 32'(st_reg.muteCal) << vafc_pkg::MUTE_CAL_BIT;
			vafc_pkg::IDX_STAT:
				rdMux = 32'(st_reg.busy) << vafc_pkg::BUSY_BIT;
			default: rdMux = 32'h00000000;
		endcase
	end

	// Next state: bus handshake, register writes and calibration search
	always_comb begin
		st_next = st_reg;
		newBest = st_reg.best;
		decided = st_reg.trial;
		startCal = 1'b0;
		st_next.serStrobe = 1'b0;
		st_next.preCnt = tick ? 5'h00 : st_reg.preCnt + 5'h01;
		// One wait cycle per access; the answer is ready at the next edge
		req = (read | write) & st_reg.waitReq;
		st_next.waitReq = ~req;
		if (req) begin
			st_next.rdData = rdMux;
		end
		// Partial-word writes are ignored: every field spans low lanes
		wrAck = write & ~st_reg.waitReq & (byteenable == 4'hf);

		unique case (st_reg.fsm)
			vafc_pkg::CAL_IDLE: begin
			end
			vafc_pkg::CAL_WAITK: if (tick) begin
				st_next.tickCnt = st_reg.tickCnt + 9'h001;
				if (st_reg.tickCnt == vafc_pkg::WAIT_TICKS - 9'h001) begin
					st_next.tickCnt = 9'h000;
					st_next.fsm = vafc_pkg::CAL_XFER;
				end
			end
			vafc_pkg::CAL_XFER: if (tick) begin
				st_next.tickCnt = st_reg.tickCnt + 9'h001;
				// Serial word shifts one bit per tick, MSB first
				if (st_reg.tickCnt < 9'(vafc_pkg::SER_BITS)) begin
					st_next.serData = st_reg.shift[15];
					st_next.serStrobe = 1'b1;
					st_next.serEn = 1'b1;
					st_next.shift = {st_reg.shift[14:0], 1'b0};
				end else begin
					st_next.serEn = 1'b0;
				end
				if (st_reg.tickCnt == 9'(vafc_pkg::XFER_TICKS) - 9'h001) begin
					st_next.tickCnt = 9'h000;
					st_next.bandOut = st_reg.trial;
					if (st_reg.measLeft == 3'h0) begin
						st_next.fsm = vafc_pkg::CAL_LOAD;
					end else begin
						st_next.fsm = vafc_pkg::CAL_MEAS;
						st_next.winCnt = 22'h000000;
						st_next.vcoCnt = 32'h00000000;
					end
				end
			end
			vafc_pkg::CAL_MEAS: begin
				st_next.vcoCnt = total;
				st_next.winCnt = st_reg.winCnt + 22'h000001;
				if (st_reg.winCnt == winLast) begin
					// Keep the closest setting seen, then decide this bit
					if (err < st_reg.bestErr) begin
						newBest = st_reg.trial;
						st_next.bestErr = err;
					end
					st_next.best = newBest;
					if (total > expCount) begin
						decided[st_reg.bitIdx] = 1'b0;
					end
					st_next.measLeft = st_reg.measLeft - 3'h1;
					st_next.bitIdx = st_reg.bitIdx - 3'h1;
					st_next.trial = (st_reg.measLeft == 3'h1) ? newBest :
						decided | (8'h01 << (st_reg.bitIdx - 3'h1));
					st_next.shift = {7'h00, st_next.trial, 1'b0};
					st_next.tickCnt = 9'h000;
					// Restart the tick phase so a window never hides in a tick
					st_next.preCnt = 5'h00;
					st_next.fsm = vafc_pkg::CAL_XFER;
				end
			end
			vafc_pkg::CAL_LOAD: begin
				// Pending frequency goes live only with the final band
				st_next.prescInt = st_reg.intReg;
				if (st_reg.fracMode) begin
					st_next.sdFrac = st_reg.fracReg;
				end
				st_next.bandReg = st_reg.best;
				st_next.fsm = vafc_pkg::CAL_IDLE;
			end
			default: st_next.fsm = vafc_pkg::CAL_IDLE;
		endcase

		// Register writes; a frequency write restarts a running search
		if (wrAck) begin
			unique case (idx)
				vafc_pkg::IDX_INT: begin
					st_next.intReg = writedata[18:0];
					if (st_reg.calOff) begin
						st_next.prescInt = writedata[18:0];
					end else if (!st_reg.fracMode) begin
						startCal = 1'b1;
					end
				end
				vafc_pkg::IDX_FRAC: begin
					st_next.fracReg = writedata[23:0];
					if (st_reg.fracMode && st_reg.calOff) begin
						st_next.sdFrac = writedata[23:0];
					end else if (st_reg.fracMode) begin
						startCal = 1'b1;
					end
				end
				vafc_pkg::IDX_MODE:
					st_next.fracMode = writedata[vafc_pkg::MODE_FRAC_BIT];
				vafc_pkg::IDX_CAL: begin
					st_next.nCode = writedata[vafc_pkg::CAL_N_LSB +: 3];
					st_next.calOff = writedata[vafc_pkg::CAL_OFF_BIT];
					st_next.mCode = writedata[vafc_pkg::CAL_M_LSB +: 2];
				end
				vafc_pkg::IDX_BAND: begin
					st_next.bandReg = writedata[vafc_pkg::BAND_LSB +: 8];
					if (st_reg.calOff) begin
						st_next.bandOut = writedata[vafc_pkg::BAND_LSB +: 8];
					end
				end
				vafc_pkg::IDX_OUT: begin
					st_next.divider = writedata[vafc_pkg::OUT_DIV_LSB +: 6];
					st_next.gain = writedata[vafc_pkg::OUT_GAIN_LSB +: 5];
				end
				vafc_pkg::IDX_MUTE:
					st_next.muteCal = writedata[vafc_pkg::MUTE_CAL_BIT];
				default: begin
				end
			endcase
		end
		if (startCal) begin
			st_next.fsm = vafc_pkg::CAL_WAITK;
			st_next.tickCnt = 9'h000;
			st_next.preCnt = 5'h00;
			st_next.trial = vafc_pkg::FIRST_BAND;
			st_next.best = vafc_pkg::FIRST_BAND;
			st_next.bestErr = 32'hffffffff;
			st_next.bitIdx = 3'h7;
			st_next.measLeft = vafc_pkg::MEAS_COUNT;
			st_next.shift = {7'h00, vafc_pkg::FIRST_BAND, 1'b0};
			st_next.serEn = 1'b0;
		end
		// Mute gates the output stage only; nothing else stops
		st_next.busy = (st_next.fsm != vafc_pkg::CAL_IDLE);
		st_next.mute = (st_next.divider == 6'h00) |
			(st_next.muteCal & st_next.busy);
	end

	// State register
	always_ff @(posedge clock) begin
		if (srst) begin
			st_reg <= '0;
			st_reg.waitReq <= 1'b1;
			st_reg.intReg <= vafc_pkg::RST_INT;
			st_reg.prescInt <= vafc_pkg::RST_INT;
			st_reg.divider <= vafc_pkg::RST_DIV;
			st_reg.gain <= vafc_pkg::RST_GAIN;
			st_reg.fsm <= vafc_pkg::CAL_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	assign readdata = st_reg.rdData;
	assign waitrequest = st_reg.waitReq;
	assign bandSwitch = st_reg.bandOut;
	assign prescalerInt = st_reg.prescInt;
	assign modulatorFrac = st_reg.sdFrac;
	assign outputGain = st_reg.gain;
	assign outputDivider = st_reg.divider;
	assign outputMute = st_reg.mute;
	assign calBusy = st_reg.busy;
	assign oscSerialData = st_reg.serData;
	assign oscSerialStrobe = st_reg.serStrobe;
	assign oscSerialEnable = st_reg.serEn;

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	logic [21:0] measLen;
	always_ff @(posedge clock) begin
		if (srst || st_reg.fsm != vafc_pkg::CAL_MEAS) begin
			measLen <= 22'h000000;
		end else begin
			measLen <= measLen + 22'h000001;
		end
	end

	sequence s_wrAck(logic [4:0] i);
		write && !waitrequest && byteenable == 4'hf && idx == i;
	endsequence

	sequence s_calDone;
		$fell(calBusy);
	endsequence

	a_bus_one_wait: assert property ((read || write) && waitrequest
		|=> !waitrequest ##1 waitrequest)
		else $error("bus answer not after one wait cycle");
	a_n_code_four: assert property (
		st_reg.nCode == 3'h4 |-> nExp == 4'h5)
		else $error("length code 4 must give exponent 5");
	a_window_length: assert property (
		st_reg.fsm == vafc_pkg::CAL_MEAS &&
		st_next.fsm == vafc_pkg::CAL_XFER && !startCal
		|-> measLen == winLast)
		else $error("measurement window length wrong");
	a_band_direct: assert property (
		s_wrAck(vafc_pkg::IDX_BAND) ##0 st_reg.calOff
		|=> bandSwitch == $past(writedata[8:1]))
		else $error("manual band not applied");
	a_frac_direct: assert property (
		s_wrAck(vafc_pkg::IDX_FRAC) ##0
		(st_reg.fracMode && st_reg.calOff)
		|=> modulatorFrac == $past(writedata[23:0]) && !calBusy)
		else $error("fraction not loaded at once");
	a_frac_deferred: assert property (
		s_wrAck(vafc_pkg::IDX_FRAC) ##0
		(st_reg.fracMode && !st_reg.calOff)
		|=> calBusy && $stable(modulatorFrac))
		else $error("fraction write did not start calibration");
	a_int_direct: assert property (
		s_wrAck(vafc_pkg::IDX_INT) ##0 st_reg.calOff
		|=> prescalerInt == $past(writedata[18:0]))
		else $error("integer not loaded at once");
	a_int_starts: assert property (
		s_wrAck(vafc_pkg::IDX_INT) ##0
		(!st_reg.fracMode && !st_reg.calOff) |=> calBusy)
		else $error("integer write did not start calibration");
	a_load_at_end: assert property (
		s_calDone ##0 (st_reg.fracMode && !startCal)
		|-> modulatorFrac == st_reg.fracReg &&
		bandSwitch == st_reg.bandReg)
		else $error("pending value not loaded after calibration");
	a_zero_div_mute: assert property (
		outputDivider == 6'h00 |-> outputMute)
		else $error("divider zero not muted");
	a_cal_mute: assert property (
		calBusy && st_reg.muteCal |-> outputMute)
		else $error("output live during calibration");
	a_strobe_tick: assert property (
		oscSerialStrobe |-> oscSerialEnable && $past(tick))
		else $error("serial bit not on a state-machine tick");
endmodule

// ### tb/vafc_host_model.sv
/*
 Host stand-in: an Avalon-MM master driven through one task, and a
 crude oscillator whose cycles per reference cycle follow the band.
 Assumes one bench process calls the task, and the slave answers.
*/
`timescale 1ns/100ps
module vafc_host_model (
	input wire logic clock,
	input wire logic waitrequest,
	input wire logic [31:0] readdata,
	input wire logic [7:0] bandSwitch,
	output logic [6:0] address,
	output logic read,
	output logic write,
	output logic [3:0] byteenable,
	output logic [31:0] writedata,
	output logic [7:0] vcoPulses
);
	// Higher code runs faster; the two low bits fall below resolution
	assign vcoPulses = {2'h0, bandSwitch[7:2]};

	// Idle bus from time zero
	initial begin
		address = 7'h00;
		read = 1'b0;
		write = 1'b0;
		byteenable = 4'h0;
		writedata = 32'h0;
	end

	// Held until waitrequest is seen low at an edge; bounded wait
	task automatic access(input logic rd, input logic [4:0] idx,
		input logic [31:0] d, input logic [3:0] be,
		output logic [31:0] q, output logic ok);
		int i;
		ok = 1'b0;
		q = 32'h0;
		@(posedge clock);
		address <= {idx, 2'h0};
		read <= rd;
		write <= ~rd;
		byteenable <= be;
		writedata <= d;
		for (i = 0; i < 50; i++) begin
			@(posedge clock);
			if (waitrequest === 1'b0) begin
				ok = 1'b1;
				q = readdata;
				break;
			end
		end
		read <= 1'b0;
		write <= 1'b0;
	endtask
endmodule

// ### tb/test_vco_auto_band_calibration_freq_change.sv
/*
 Self-checking bench for the band calibration block.
 Assumes a 100 MHz reference, R of 1 or 2 and the host model as master.
*/
`timescale 1ns/100ps
module test_vco_auto_band_calibration_freq_change;
	logic clock, srst, read, write, waitrequest, outputMute, calBusy;
	logic oscSerialData, oscSerialStrobe, oscSerialEnable;
	logic [6:0] address;
	logic [3:0] byteenable;
	logic [31:0] writedata, readdata;
	logic [13:0] refDivider;
	logic [7:0] vcoPulses, bandSwitch;
	logic [18:0] prescalerInt;
	logic [23:0] modulatorFrac;
	logic [4:0] outputGain;
	logic [5:0] outputDivider;
	int nErrors = 0;
	int cmpCount = 0;

	vafc_vco_auto_band_calibration vafc_vco_auto_band_calibration_inst (.clock, .srst, .address,
		.read, .write, .byteenable, .writedata, .readdata, .waitrequest,
		.refDivider, .vcoPulses, .bandSwitch, .prescalerInt,
		.modulatorFrac, .outputGain, .outputDivider, .outputMute,
		.calBusy, .oscSerialData, .oscSerialStrobe, .oscSerialEnable);
	vafc_host_model vafc_host_model_inst (.clock, .waitrequest,
		.readdata, .bandSwitch, .address, .read, .write, .byteenable,
		.writedata, .vcoPulses);

	// Reference clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic close_out();
		$display("Compares %0d mismatches %0d", cmpCount, nErrors);
		if (nErrors == 0 && cmpCount > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			nErrors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// A lost handshake ends the run; #1 lets the ack edge land
	task automatic acc(input logic rd, input logic [4:0] idx,
		input logic [31:0] d, input logic [3:0] be, output logic [31:0] q);
		logic ok;
		vafc_host_model_inst.access(rd, idx, d, be, q, ok);
		chk("bus ack", {31'h0, ok}, 32'h1);
		if (ok !== 1'b1) begin
			close_out();
		end
		#1;
	endtask

	task automatic wr(input logic [4:0] idx, input logic [31:0] d,
		input logic [3:0] be = 4'hf);
		logic [31:0] q;
		acc(1'b0, idx, d, be, q);
	endtask

	task automatic rd(input logic [4:0] idx, input logic [31:0] exp);
		logic [31:0] q;
		acc(1'b1, idx, 32'h0, 4'hf, q);
		chk("readdata", q, exp);
	endtask

	// Follows one calibration; lo is the least busy cycle count, sl the slack above it
	task automatic cal_run(input int lo, input int sl, input logic [7:0] be);
		int dur, strobes, i;
		logic early, loud;
		logic inTime;
		logic [15:0] word;
		logic [18:0] p0;
		logic [23:0] f0;
		dur = 0;
		strobes = 0;
		early = 1'b0;
		loud = 1'b0;
		word = 16'h0000;
		p0 = prescalerInt;
		f0 = modulatorFrac;
		chk("cal start", {31'h0, calBusy}, 32'h1);
		for (i = 0; i < 20000; i++) begin
			@(posedge clock);
			#1;
			// The last sixteen bits seen are the final transfer's word
			if (oscSerialStrobe === 1'b1) begin
				strobes++;
				word = {word[14:0], oscSerialData};
			end
			if (calBusy !== 1'b1) break;
			dur++;
			if (outputMute !== 1'b1) loud = 1'b1;
			if (prescalerInt !== p0 || modulatorFrac !== f0) early = 1'b1;
		end
		chk("cal done", {31'h0, calBusy}, 32'h0);
		if (calBusy !== 1'b0) close_out();
		inTime = (dur >= lo && dur <= lo + sl);
		chk("cal time", {31'h0, inTime}, 32'h1);
		chk("serial bits", strobes, 32'h70);
		chk("serial word", word, {7'h00, be, 1'b0});
		chk("band", bandSwitch, be);
		chk("mute held", {31'h0, loud}, 32'h0);
		chk("early load", {31'h0, early}, 32'h0);
		chk("unmuted", {31'h0, outputMute}, 32'h0);
	endtask

	task automatic s_output();
		wr(vafc_pkg::IDX_OUT, {21'h0, 5'h15, 6'h00});
		chk("gain", outputGain, 5'h15);
		chk("mute div0", {31'h0, outputMute}, 32'h1);
		wr(vafc_pkg::IDX_OUT, 32'h2, 4'h1);
		chk("part write", {31'h0, outputMute}, 32'h1);
		wr(vafc_pkg::IDX_OUT, {21'h0, 5'h15, 6'h02});
		chk("divider", outputDivider, 6'h02);
		chk("unmute", {31'h0, outputMute}, 32'h0);
	endtask

	// Hop with the search off: band first, then frequency
	task automatic s_manual();
		wr(vafc_pkg::IDX_CAL, 32'h2800);
		wr(vafc_pkg::IDX_BAND, 32'hb4);
		chk("manual band", bandSwitch, 8'h5a);
		wr(vafc_pkg::IDX_INT, 32'h25);
		chk("int now", prescalerInt, 19'h00025);
		wr(vafc_pkg::IDX_MODE, 32'h800);
		wr(vafc_pkg::IDX_FRAC, 32'h123456);
		chk("frac now", modulatorFrac, 24'h123456);
		chk("no cal", {calBusy, bandSwitch}, 9'h05a);
		rd(vafc_pkg::IDX_BAND, 32'hb4);
		wr(vafc_pkg::IDX_MODE, 32'h0);
	endtask

	// Integer mode, tick 4 clocks so the FSM stays at 25 MHz
	task automatic s_int_cal();
		wr(vafc_pkg::IDX_CAL, 32'h2000);
		wr(vafc_pkg::IDX_MUTE, 32'h80);
		wr(vafc_pkg::IDX_FRAC, 32'h1);
		chk("frac ignored", {31'h0, calBusy}, 32'h0);
		wr(vafc_pkg::IDX_INT, 32'h28);
		cal_run(2102, 68, 8'ha0);
		chk("int loaded", prescalerInt, 19'h00028);
		rd(vafc_pkg::IDX_BAND, 32'h140);
		// Slowest tick (m=5) with R of 2: window and counts both double
		@(posedge clock);
		refDivider <= 14'h0002;
		wr(vafc_pkg::IDX_CAL, 32'h6000);
		wr(vafc_pkg::IDX_INT, 32'h28);
		cal_run(16780, 68, 8'h50);
		rd(vafc_pkg::IDX_BAND, 32'ha0);
		@(posedge clock);
		refDivider <= 14'h0001;
	endtask

	// Fractional mode, n code 4 (n=5), tick 16 clocks
	task automatic s_frac_cal();
		int k;
		wr(vafc_pkg::IDX_CAL, 32'h4004);
		wr(vafc_pkg::IDX_MODE, 32'h800);
		wr(vafc_pkg::IDX_INT, 32'h30);
		chk("int stored", {calBusy, prescalerInt}, 20'h00028);
		for (k = 0; k < 2; k++) begin
			wr(vafc_pkg::IDX_FRAC, 32'h400000);
			cal_run(8576, 260, 8'hc0);
			chk("frac loaded", modulatorFrac, 24'h400000);
			chk("int after", prescalerInt, 19'h00030);
		end
	endtask

	// Main sequence
	initial begin
		srst = 1'b1;
		refDivider = 14'h0001;
		repeat (10) @(posedge clock);
		srst <= 1'b0;
		#1;
		chk("idle", {calBusy, outputMute, outputDivider}, 8'h01);
		rd(5'h01, 32'h0);
		rd(vafc_pkg::IDX_STAT, 32'h0);
		s_output();
		s_manual();
		s_int_cal();
		s_frac_cal();
		close_out();
	end
endmodule
